// ---- lssc_pkg.sv ----
package lssc_pkg;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] MODE_SEL_OFFSET = 8'h01;
  localparam logic [7:0] CH1_DRIVE_OFFSET = 8'h02;
  localparam logic [7:0] CH2_DRIVE_OFFSET = 8'h03;
  localparam logic [7:0] CH3_DRIVE_OFFSET = 8'h04;
  localparam logic [7:0] CH4_DRIVE_OFFSET = 8'h05;
  localparam logic [7:0] SUPERVISION_OFFSET = 8'h29;
  localparam logic [7:0] HEADROOM_STATUS_OFFSET = 8'h2b;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] MODE_SEL_RESET = 8'h03;
  localparam logic [7:0] CH1_DRIVE_RESET = 8'h40;
  localparam logic [7:0] CHX_DRIVE_RESET = 8'h00;
  localparam logic [1:0] VMON_SEL_RESET = 2'h0;
  localparam logic SHUTDOWN_EN_RESET = 1'b1;
  localparam logic THERMAL_WATCH_RESET = 1'b1;

  // ****************************************************
  // supervision register field positions
  // ****************************************************
  localparam int VMON_SEL_LSB = 5;
  localparam int SHUTDOWN_EN_BIT = 4;
  localparam int THERMAL_CLEAR_BIT = 2;
  localparam int THERMAL_FLAG_BIT = 1;
  localparam int THERMAL_WATCH_BIT = 0;

  // ****************************************************
  // channel mode codes
  // ****************************************************
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_PATTERN = 2'h3;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int IF_DEBOUNCE_MS = 130;
  localparam int VMON_DEBOUNCE_MS = 100;
  localparam int DEB_CNT_W = 16;

endpackage

// ---- lssc_debounce.sv ----
`timescale 1ns/1ps
module lssc_debounce
  import lssc_pkg::*;
#(
  parameter int COUNT_MS = IF_DEBOUNCE_MS
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic level_i,
  output logic stable_o
);

  typedef struct packed {
    logic [DEB_CNT_W-1:0] cnt;
    logic stable;
  } lssc_deb_type;

  lssc_deb_type r;
  lssc_deb_type next_r;

  // level must stay high for COUNT_MS ticks; any drop restarts
  always_comb
  begin
    next_r = r;
    if (!level_i)
    begin
      next_r.cnt = '0;
      next_r.stable = 1'b0;
    end
    else if (tick_i && !r.stable)
    begin
      if (r.cnt == DEB_CNT_W'(COUNT_MS - 1))
        next_r.stable = 1'b1;
      else
        next_r.cnt = r.cnt + DEB_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      r <= '0;
    else
      r <= next_r;
  end

  assign stable_o = r.stable;

endmodule

// ---- lssc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - each channel mode: 00 off, 01 on, 10 pwm gated, 11 pattern gated
// - modes share one register, channel four high bits; channel one resets to pattern
// - 8-bit drive code per channel, 0.1 mA per step up to 25.5 mA
// - channel one drive code resets to 0x40, others to zero
// - pwm mode follows internal or external pwm; pattern mode follows pattern generator
// - read-only status holds one low-headroom flag per channel, reset zero
// - battery below power-on level returns all registers to defaults and shuts the device down
// - serial clock low with gpio low forces reset after debounce
// - serial clock debounce is 130 ms, held as a parameter
// - battery monitor comparison debounced about 100 ms before standby
// - two-bit monitor select in bits 6:5 picks threshold, zero means off
// - battery monitor stays disabled until a non-zero select is written
// - bit 4, reset 1, enables serial-clock-low shutdown
// - bit 1 reads junction over-temperature flag
// - bit 2 write-one clears the over-temperature flag, reads zero
// - bit 0, reset 1, enables temperature supervision
// - over-temperature disables sinks and pump, resumes after hysteresis
// - flag stays set after recovery, reads do not clear it
module lssc_top
  import lssc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int IF_DEB_MS = IF_DEBOUNCE_MS,
  parameter int VMON_DEB_MS = VMON_DEBOUNCE_MS,
  parameter int CHANNELS = 4
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic scl_i,
  input wire logic gpio_i,
  input wire logic bat_por_i,
  input wire logic vbat_low_i,
  input wire logic temp_hot_i,
  input wire logic [CHANNELS-1:0] headroom_low_i,
  input wire logic pwm_int_i,
  input wire logic pwm_ext_sel_i,
  input wire logic pattern_i,
  output logic [CHANNELS-1:0] sink_on_o,
  output logic [7:0] ch1_drive_code_o,
  output logic [7:0] ch2_drive_code_o,
  output logic [7:0] ch3_drive_code_o,
  output logic [7:0] ch4_drive_code_o,
  output logic [1:0] vmon_sel_o,
  output logic pump_disable_o,
  output logic shutdown_o,
  output logic standby_o
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    logic [7:0] mode_sel;
    logic [3:0][7:0] drive;
    logic [1:0] vmon_sel;
    logic shutdown_en;
    logic thermal_watch_en;
    logic thermal_fault_flag;
    logic [7:0] rdata;
    logic [CHANNELS-1:0] sink_on;
    logic pump_disable;
    logic shutdown;
    logic scl_s1;
    logic scl_s2;
    logic gpio_s1;
    logic gpio_s2;
    logic por_s1;
    logic por_s2;
    logic vlow_s1;
    logic vlow_s2;
    logic hot_s1;
    logic hot_s2;
    logic [CHANNELS-1:0] head_s1;
    logic [CHANNELS-1:0] head_s2;
    logic [15:0] tick_cnt;
    logic ms_tick;
  } lssc_state_type;

  lssc_state_type r;
  lssc_state_type next_r;
  logic if_reset;
  logic vmon_trip;
  logic [7:0] mode_read;
  logic [7:0] sup_read;
  logic [7:0] status_read;
  logic [CHANNELS-1:0] gate;
  logic [7:0] read_mux;
  logic wr_mode;
  logic [3:0] wr_drive;
  logic wr_sup;
  logic thermal_clear;
  logic hot_seen;
  logic soft_reset;
  logic if_level;
  logic vmon_level;
  logic pwm_level;

  // ****************************************************
  // debouncers
  // ****************************************************
  // clock low plus gpio low, only while shutdown enabled
  // a cleared enable holds the interface debouncer idle
  assign if_level = r.shutdown_en & ~r.scl_s2 & ~r.gpio_s2;
  // no comparison while select is zero
  assign vmon_level = (r.vmon_sel != VMON_SEL_RESET) & r.vlow_s2;

  lssc_debounce #(
    .COUNT_MS(IF_DEB_MS)
  ) u_if_deb (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(r.ms_tick),
    .level_i(if_level),
    .stable_o(if_reset)
  );

  // battery monitor dip filter, vbat_low_i going low before the count ends restarts it
  lssc_debounce #(
    .COUNT_MS(VMON_DEB_MS)
  ) u_vmon_deb (
    .tick_i(r.ms_tick),
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .level_i(vmon_level),
    .stable_o(vmon_trip)
  );

  // ****************************************************
  // channel gating
  // ****************************************************
  // external pwm arrives on the synced gpio pin
  assign pwm_level = pwm_ext_sel_i ? r.gpio_s2 : pwm_int_i;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : gen_gate
      always_comb
      begin
        unique case (r.mode_sel[2*g +: 2])
          MODE_OFF: gate[g] = 1'b0;
          MODE_ON: gate[g] = 1'b1;
          MODE_PWM: gate[g] = pwm_level;
          MODE_PATTERN: gate[g] = pattern_i;
        endcase
      end
    end
  endgenerate

  // ****************************************************
  // register read views
  // ****************************************************
  always_comb
  begin
    mode_read = r.mode_sel;
    sup_read = '0;
    sup_read[VMON_SEL_LSB +: 2] = r.vmon_sel;
    sup_read[SHUTDOWN_EN_BIT] = r.shutdown_en;
    sup_read[THERMAL_FLAG_BIT] = r.thermal_fault_flag;
    sup_read[THERMAL_WATCH_BIT] = r.thermal_watch_en;
    status_read = '0;
    status_read[CHANNELS-1:0] = r.head_s2;
  end

  // ****************************************************
  // read mux
  // ****************************************************
  always_comb
  begin
    unique case (reg_addr_i)
      MODE_SEL_OFFSET: read_mux = mode_read;
      CH1_DRIVE_OFFSET: read_mux = r.drive[0];
      CH2_DRIVE_OFFSET: read_mux = r.drive[1];
      CH3_DRIVE_OFFSET: read_mux = r.drive[2];
      CH4_DRIVE_OFFSET: read_mux = r.drive[3];
      SUPERVISION_OFFSET: read_mux = sup_read;
      HEADROOM_STATUS_OFFSET: read_mux = status_read;
      default: read_mux = 8'h00;
    endcase
  end

  // ****************************************************
  // write decode
  // ****************************************************
  always_comb
  begin
    wr_mode = reg_wr_i && (reg_addr_i == MODE_SEL_OFFSET);
    wr_drive[0] = reg_wr_i && (reg_addr_i == CH1_DRIVE_OFFSET);
    wr_drive[1] = reg_wr_i && (reg_addr_i == CH2_DRIVE_OFFSET);
    wr_drive[2] = reg_wr_i && (reg_addr_i == CH3_DRIVE_OFFSET);
    wr_drive[3] = reg_wr_i && (reg_addr_i == CH4_DRIVE_OFFSET);
    wr_sup = reg_wr_i && (reg_addr_i == SUPERVISION_OFFSET);
    // clear acts on the write itself, the bit is never stored
    thermal_clear = wr_sup && reg_wdata_i[THERMAL_CLEAR_BIT];
  end

  // ****************************************************
  // protection and reset causes
  // ****************************************************
  // comparator only counts while supervision is enabled
  assign hot_seen = r.thermal_watch_en & r.hot_s2;
  // either cause forces the defaults and holds them while it lasts
  assign soft_reset = r.por_s2 | if_reset;

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    next_r = r;
    // two-flop synchronisers for every pin-level input
    next_r.scl_s1 = scl_i;
    next_r.scl_s2 = r.scl_s1;
    next_r.gpio_s1 = gpio_i;
    next_r.gpio_s2 = r.gpio_s1;
    next_r.por_s1 = bat_por_i;
    next_r.por_s2 = r.por_s1;
    next_r.vlow_s1 = vbat_low_i;
    next_r.vlow_s2 = r.vlow_s1;
    next_r.hot_s1 = temp_hot_i;
    next_r.hot_s2 = r.hot_s1;
    next_r.head_s1 = headroom_low_i;
    next_r.head_s2 = r.head_s1;

    // ms tick is free-running, so a debounce lasts N-1 to N tick periods
    next_r.ms_tick = 1'b0;
    if (r.tick_cnt == 16'(TICK_LEN - 1))
    begin
      next_r.tick_cnt = '0;
      next_r.ms_tick = 1'b1;
    end
    else
      next_r.tick_cnt = r.tick_cnt + 16'h0001;

    // read data is captured once and held until the next read
    if (reg_rd_i)
      next_r.rdata = read_mux;

    if (wr_mode)
      next_r.mode_sel = reg_wdata_i;
    if (wr_drive[0])
      next_r.drive[0] = reg_wdata_i;
    if (wr_drive[1])
      next_r.drive[1] = reg_wdata_i;
    if (wr_drive[2])
      next_r.drive[2] = reg_wdata_i;
    if (wr_drive[3])
      next_r.drive[3] = reg_wdata_i;
    // bits 7, 3 and 1 are dropped, bit 2 is never stored
    if (wr_sup)
    begin
      next_r.vmon_sel = reg_wdata_i[VMON_SEL_LSB +: 2];
      next_r.shutdown_en = reg_wdata_i[SHUTDOWN_EN_BIT];
      next_r.thermal_watch_en = reg_wdata_i[THERMAL_WATCH_BIT];
    end

    if (thermal_clear)
      next_r.thermal_fault_flag = 1'b0;
    // the clear bit or a soft reset drops it; a hot sample wins over a clear
    if (hot_seen)
      next_r.thermal_fault_flag = 1'b1;

    // sinks and pump follow the comparator with its hysteresis
    next_r.pump_disable = hot_seen;
    next_r.sink_on = hot_seen ? '0 : gate;
    next_r.shutdown = soft_reset;

    // supply or interface reset returns all registers to defaults
    // a write in the same cycle is lost on purpose
    if (soft_reset)
    begin
      next_r.mode_sel = MODE_SEL_RESET;
      next_r.drive[0] = CH1_DRIVE_RESET;
      next_r.drive[1] = CHX_DRIVE_RESET;
      next_r.drive[2] = CHX_DRIVE_RESET;
      next_r.drive[3] = CHX_DRIVE_RESET;
      next_r.vmon_sel = VMON_SEL_RESET;
      next_r.shutdown_en = SHUTDOWN_EN_RESET;
      next_r.thermal_watch_en = THERMAL_WATCH_RESET;
      next_r.thermal_fault_flag = 1'b0;
      next_r.sink_on = '0;
    end
  end

  // ****************************************************
  // state register
  // ****************************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.mode_sel <= MODE_SEL_RESET;
      r.drive[0] <= CH1_DRIVE_RESET;
      r.shutdown_en <= SHUTDOWN_EN_RESET;
      r.thermal_watch_en <= THERMAL_WATCH_RESET;
      // scl idles high, so release starts no interface debounce
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
    end
    else
      r <= next_r;
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign reg_rdata_o = r.rdata;
  assign sink_on_o = r.sink_on;
  assign ch1_drive_code_o = r.drive[0];
  assign ch2_drive_code_o = r.drive[1];
  assign ch3_drive_code_o = r.drive[2];
  assign ch4_drive_code_o = r.drive[3];
  assign vmon_sel_o = r.vmon_sel;
  assign pump_disable_o = r.pump_disable;
  assign shutdown_o = r.shutdown;
  // standby comes straight from the debouncer flop
  assign standby_o = vmon_trip;

endmodule

// ---- lssc_props_properties.sv ----
`timescale 1ns/1ps
module lssc_props
  import lssc_pkg::*;
#(
  parameter int TICK_LEN = 10,
  parameter int CHANNELS = 4
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic scl_i,
  input wire logic bat_por_i,
  input wire logic vbat_low_i,
  input wire logic temp_hot_i,
  input wire logic [CHANNELS-1:0] sink_on_o,
  input wire logic [7:0] ch1_drive_code_o,
  input wire logic [1:0] vmon_sel_o,
  input wire logic pump_disable_o,
  input wire logic shutdown_o,
  input wire logic standby_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  a_sinks_off_hot: assert property (
    pump_disable_o |-> sink_on_o == '0) else $error("sink on during pump disable");
  a_pump_cause: assert property (
    $rose(pump_disable_o) |-> $past(temp_hot_i, 3)) else $error("pump disable without heat");
  a_drive_write: assert property (
    reg_wr_i && reg_addr_i == CH1_DRIVE_OFFSET && !shutdown_o && !bat_por_i
    |=> ch1_drive_code_o == $past(reg_wdata_i)) else $error("drive code not written");
  a_mode_off_sinks: assert property (
    (reg_wr_i && reg_addr_i == MODE_SEL_OFFSET && reg_wdata_i == 8'h00) ##1 !reg_wr_i
    |=> sink_on_o == '0) else $error("sink on in off mode");
  a_mode_on_sinks: assert property (
    (reg_wr_i && reg_addr_i == MODE_SEL_OFFSET && reg_wdata_i == 8'h55 && !pump_disable_o)
    ##1 !reg_wr_i |=> sink_on_o == '1) else $error("sink off in on mode");
  a_standby_cause: assert property (
    $rose(standby_o) |-> vmon_sel_o != 2'h0 && $past(vbat_low_i, TICK_LEN))
    else $error("standby without debounced low battery");
  a_por_defaults: assert property (
    bat_por_i [*5] |=> shutdown_o && vmon_sel_o == 2'h0 && ch1_drive_code_o == 8'h40)
    else $error("power-on reset not applied");
  a_idle_running: assert property (
    (scl_i && !bat_por_i) [*8] |=> !shutdown_o) else $error("shutdown with clock high");
endmodule

// ---- lssc_host_model.sv ----
`timescale 1ns/1ps
module lssc_host_model
(
  input wire logic ref_clk_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // clear bit is a plain one-byte write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import lssc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl_i = 1'b1;
  logic gpio_i = 1'b1;
  logic bat_por_i = 1'b0;
  logic vbat_low_i = 1'b0;
  logic temp_hot_i = 1'b0;
  logic [3:0] headroom_low_i = 4'h0;
  logic pwm_int_i = 1'b0;
  logic pwm_ext_sel_i = 1'b0;
  logic pattern_i = 1'b0;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, c1, c2, c3, c4;
  logic reg_wr_i, reg_rd_i, pump_disable_o, shutdown_o, standby_o;
  logic [3:0] sink_on_o;
  logic [1:0] vmon_sel_o;
  int n_errors = 0;
  int total_checks = 0;
  logic [15:0] rst_tab [8] = '{16'h0103, 16'h0240, 16'h0300, 16'h0400, 16'h0500,
    16'h2911, 16'h2b00, 16'h0600};
  logic [23:0] rw_tab [8] = '{24'h01e4e4, 24'h02a5a5, 24'h035a5a, 24'h04ffff,
    24'h058181, 24'h29ff71, 24'h2bff00, 24'h06ff00};
  // {mode, pwm source, pattern, internal pwm, expected sinks}
  logic [15:0] mode_tab [7] = '{16'h0000, 16'h550f, 16'haa00, 16'haa2f, 16'haa8f, 16'hff4f,
    16'he486};
  always #10 ref_clk_i = ~ref_clk_i;
  lssc_top #(.TICK_LEN(10), .IF_DEB_MS(3), .VMON_DEB_MS(2), .CHANNELS(4)) dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .gpio_i(gpio_i), .bat_por_i(bat_por_i),
    .vbat_low_i(vbat_low_i), .temp_hot_i(temp_hot_i), .headroom_low_i(headroom_low_i),
    .pwm_int_i(pwm_int_i), .pwm_ext_sel_i(pwm_ext_sel_i), .pattern_i(pattern_i),
    .sink_on_o(sink_on_o), .ch1_drive_code_o(c1), .ch2_drive_code_o(c2),
    .ch3_drive_code_o(c3), .ch4_drive_code_o(c4), .vmon_sel_o(vmon_sel_o),
    .pump_disable_o(pump_disable_o), .shutdown_o(shutdown_o), .standby_o(standby_o));
  lssc_host_model host_u (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));
  // ****************************************************
  // shared tasks
  // ****************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk_i);
    n_errors++;
    test_done;
  end
  initial
  begin
    wt(5);
    rst_i = 1'b0;
    foreach (rst_tab[i]) rdc(rst_tab[i][15:8], rst_tab[i][7:0]);
    chk(c1, 8'h40);
    $display("test reset values done");
    vbat_low_i = 1'b1;
    wt(40);
    chk({7'h0, standby_o}, 8'h00);
    host_u.wr(8'h29, 8'h31);
    wt(40);
    chk({7'h0, standby_o}, 8'h01);
    chk({6'h0, vmon_sel_o}, 8'h01);
    vbat_low_i = 1'b0;
    wt(5);
    chk({7'h0, standby_o}, 8'h00);
    $display("test battery monitor done");
    foreach (rw_tab[i])
    begin
      host_u.wr(rw_tab[i][23:16], rw_tab[i][15:8]);
      rdc(rw_tab[i][23:16], rw_tab[i][7:0]);
    end
    chk(c2, 8'h5a);
    chk(c3, 8'hff);
    chk(c4, 8'h81);
    chk({6'h0, vmon_sel_o}, 8'h03);
    $display("test register access done");
    foreach (mode_tab[i])
    begin
      pwm_ext_sel_i = mode_tab[i][7];
      pattern_i = mode_tab[i][6];
      pwm_int_i = mode_tab[i][5];
      host_u.wr(8'h01, mode_tab[i][15:8]);
      wt(5);
      chk({4'h0, sink_on_o}, {4'h0, mode_tab[i][3:0]});
    end
    headroom_low_i = 4'ha;
    wt(4);
    rdc(8'h2b, 8'h0a);
    $display("test channel modes done");
    host_u.wr(8'h01, 8'h55);
    temp_hot_i = 1'b1;
    wt(5);
    chk({4'h0, sink_on_o}, 8'h00);
    chk({7'h0, pump_disable_o}, 8'h01);
    host_u.wr(8'h29, 8'h75);
    rdc(8'h29, 8'h73);
    temp_hot_i = 1'b0;
    wt(5);
    chk({4'h0, sink_on_o}, 8'h0f);
    rdc(8'h29, 8'h73);
    rdc(8'h29, 8'h73);
    host_u.wr(8'h29, 8'h75);
    rdc(8'h29, 8'h71);
    host_u.wr(8'h29, 8'h70);
    temp_hot_i = 1'b1;
    wt(5);
    chk({4'h0, sink_on_o}, 8'h0f);
    rdc(8'h29, 8'h70);
    temp_hot_i = 1'b0;
    $display("test thermal done");
    bat_por_i = 1'b1;
    wt(6);
    chk({7'h0, shutdown_o}, 8'h01);
    chk(c1, 8'h40);
    bat_por_i = 1'b0;
    wt(10);
    chk({7'h0, shutdown_o}, 8'h00);
    rdc(8'h29, 8'h11);
    $display("test power-on reset done");
    host_u.wr(8'h02, 8'h77);
    scl_i = 1'b0;
    gpio_i = 1'b0;
    wt(10);
    chk({7'h0, shutdown_o}, 8'h00);
    wt(60);
    chk({7'h0, shutdown_o}, 8'h01);
    rdc(8'h02, 8'h40);
    scl_i = 1'b1;
    gpio_i = 1'b1;
    wt(10);
    chk({7'h0, shutdown_o}, 8'h00);
    host_u.wr(8'h29, 8'h01);
    scl_i = 1'b0;
    gpio_i = 1'b0;
    wt(80);
    chk({7'h0, shutdown_o}, 8'h00);
    scl_i = 1'b1;
    gpio_i = 1'b1;
    $display("test interface reset done");
    test_done;
  end
endmodule
bind lssc_top lssc_props #(.TICK_LEN(TICK_LEN), .CHANNELS(CHANNELS)) chk_u (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .scl_i(scl_i), .bat_por_i(bat_por_i), .vbat_low_i(vbat_low_i),
  .temp_hot_i(temp_hot_i), .sink_on_o(sink_on_o), .ch1_drive_code_o(ch1_drive_code_o),
  .vmon_sel_o(vmon_sel_o), .pump_disable_o(pump_disable_o), .shutdown_o(shutdown_o),
  .standby_o(standby_o));
